/* File: codec_port_pkg.sv */
/*
 Constants for the codec serial port: timing counts, register offsets,
 field positions, reset values and state encodings.
 Assumes a 40 ns system clock and an APB register bus with 32-bit data.
*/
package codec_port_pkg;
   localparam int CLK_NS       = 40;
   localparam int BIT_NS       = 320;
   localparam int BIT_CYC      = BIT_NS / CLK_NS;
   // 1.5 bit times, a least time, so rounded up
   localparam int CRS_HOLD_NS  = (3 * BIT_NS) / 2;
   localparam int CRS_HOLD_CYC = (CRS_HOLD_NS + CLK_NS - 1) / CLK_NS;
   localparam int RXC_TAIL_NS  = 5 * BIT_NS;
   localparam int RXC_TAIL_CYC = (RXC_TAIL_NS + CLK_NS - 1) / CLK_NS;
   localparam int HB_WIN_NS    = 4000;
   localparam int HB_WIN_CYC   = HB_WIN_NS / CLK_NS;
   localparam int COL_WIN_NS   = 160;
   localparam int COL_WIN_CYC  = COL_WIN_NS / CLK_NS;
   localparam int CFG_SETTLE   = 3;

   localparam logic [7:0] OFS_DCR    = 8'h00;
   localparam logic [7:0] OFS_DATA_CONFIG_REG_SECOND   = 8'h04;
   localparam logic [7:0] OFS_STATUS = 8'h08;
   localparam logic [7:0] OFS_MASK   = 8'h0c;
   localparam logic [7:0] OFS_STATE  = 8'h10;

   localparam int DCR_EXT_BUS = 0;
   localparam int DATA_CONFIG_REG_SECOND_USER0  = 0;
   localparam int DATA_CONFIG_REG_SECOND_USER1  = 1;

   localparam int EV_W       = 4;
   localparam int EV_CARRIER = 0;
   localparam int EV_TX_COL  = 1;
   localparam int EV_HB_OK   = 2;
   localparam int EV_HB_MISS = 3;

   localparam int ST_CODEC_SEL = 0;
   localparam int ST_CARRIER   = 1;
   localparam int ST_COLLISION = 2;
   localparam int ST_DCR_WR    = 3;
   localparam int ST_MASTER    = 4;

   localparam logic [31:0] DCR_RST  = 32'h0000_0000;
   localparam logic [31:0] DATA_CONFIG_REG_SECOND_RST = 32'h0000_0000;
   localparam logic [31:0] MASK_RST = 32'h0000_0000;

   typedef enum logic [1:0] {
      HB_IDLE = 2'b00,
      HB_TX   = 2'b01,
      HB_WAIT = 2'b10
   } hb_state_t;
endpackage

/* File: bit_sync.sv */
/*
 Two-stage synchroniser for a group of independent single-bit levels.
 Assumes each bit is a slow level or a clock well below pclk/2.
*/
`timescale 1ns/100ps
module bit_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire logic             ce,
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta <= '0;
         q    <= '0;
      end else if (ce) begin
         meta <= d;
         q    <= meta;
      end
   end
endmodule

/* File: manchester_rx.sv */
/*
 Internal line decoder: finds carrier, recovers the bit clock and NRZ data
 from a synchronised Manchester stream.
 Assumes BIT_CYC system clocks per bit cell and an already synchronised line.
*/
`timescale 1ns/100ps
module manchester_rx #(
   parameter int BIT_CYC  = 8,
   parameter int HOLD_CYC = 12,
   parameter int TAIL_CYC = 40
) (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic ce,
   input  wire logic line,
   output logic      carrier,
   output logic      nrz,
   output logic      rclk,
   output logic      bit_strobe
);
   logic       line_d;
   logic [7:0] since_mid;
   logic [7:0] phase;
   logic [7:0] tail;

   initial begin
      if (BIT_CYC < 4 || BIT_CYC > 64 || BIT_CYC % 2 != 0 || TAIL_CYC > 255)
         $error("manchester_rx: unsupported timing parameters");
   end

   wire edge_seen = line ^ line_d;
   wire start     = !carrier && line_d && !line;
   // Edges closer than 3/4 cell to the last mid-cell edge are cell boundaries
   wire mid_edge  = carrier && edge_seen && (since_mid >= 8'(BIT_CYC * 3 / 4));
   wire drop      = carrier && !mid_edge
                    && (since_mid == 8'(BIT_CYC / 2 + HOLD_CYC - 1));
   wire running   = carrier || (tail != 8'h00);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         line_d <= 1'b0;
      end else if (ce) begin
         line_d <= line;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         carrier <= 1'b0;
      end else if (ce) begin
         if (start) begin
            carrier <= 1'b1;
         end else if (drop) begin
            carrier <= 1'b0;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         since_mid <= 8'h00;
         phase     <= 8'h00;
      end else if (ce) begin
         if (start || mid_edge) begin
            since_mid <= 8'h00;
            phase     <= 8'h00;
         end else begin
            if (since_mid != 8'hff) begin
               since_mid <= since_mid + 8'h01;
            end
            phase <= (phase == 8'(BIT_CYC - 1)) ? 8'h00 : phase + 8'h01;
         end
      end
   end

   // Each mid-cell edge sets the NRZ bit to the new line level; low-to-high is a one
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         nrz <= 1'b0;
      end else if (ce && mid_edge) begin
         nrz <= line;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tail <= 8'h00;
      end else if (ce) begin
         if (drop) begin
            tail <= 8'(TAIL_CYC);
         end else if (!carrier && tail != 8'h00) begin
            tail <= tail - 8'h01;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rclk       <= 1'b0;
         bit_strobe <= 1'b0;
      end else if (ce) begin
         bit_strobe <= carrier && (phase == 8'(BIT_CYC / 2 - 1));
         if (!running || phase == 8'h00) begin
            rclk <= 1'b0;
         end else if (phase == 8'(BIT_CYC / 2 - 1)) begin
            rclk <= 1'b1;
         end
      end
   end
endmodule

/* File: codec_serial_port.sv */
/*
 Serial port between the MAC and the line codec, with its APB registers.
 Internal mode decodes the Manchester line here and drives the results out;
 external mode takes the same shared pins as inputs from an outside codec.
 Assumes pins are asynchronous to pclk and MAC signals share pclk.
*/
`timescale 1ns/100ps
// Contract
// - Select 0 routes internal codec, drives pins
// - Carrier on first fall, holds 1.5 bits
// - Collision high on detected collision signal
// - Collision watched during transmit, SFD to end; code has no SFD and watches from the cycle after mac_tx_active rises
// - Heartbeat watched after each transmission
// - Internal NRZ data valid at clock rise
// - External data captured on clock rise
// - Recovered clock runs 5 bits after carrier
// - Data, clock pins float until config written
// - Extended bus drives user output 0 level
// - User output 1 floats until bus master
module codec_serial_port
   import codec_port_pkg::*;
#(
   parameter int BIT_CYCLES = codec_port_pkg::BIT_CYC,
   parameter int HB_CYCLES  = codec_port_pkg::HB_WIN_CYC
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        ce,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             irq,
   input  wire logic        codec_select,
   input  wire logic        line_rx,
   input  wire logic        line_cd,
   input  wire logic        rxd_pin_in,
   output logic             rxd_pin_out,
   output logic             rxd_pin_oe_n,
   input  wire logic        rxc_pin_in,
   output logic             rxc_pin_out,
   output logic             rxc_pin_oe_n,
   input  wire logic        crs_pin_in,
   output logic             crs_pin_out,
   output logic             crs_pin_oe_n,
   input  wire logic        col_pin_in,
   output logic             col_pin_out,
   output logic             col_pin_oe_n,
   input  wire logic        bus_master_grant,
   input  wire logic        mac_tx_active,
   output logic             mac_carrier,
   output logic             mac_collision,
   output logic             mac_rx_data,
   output logic             mac_rx_valid
);
   initial begin
      if (BIT_CYCLES < 4 || BIT_CYCLES > 64 || BIT_CYCLES % 2 != 0)
         $error("codec_serial_port: BIT_CYCLES must be even, 4 to 64");
      if (HB_CYCLES < 1 || HB_CYCLES > 65535)
         $error("codec_serial_port: HB_CYCLES out of range");
   end

   localparam int HOLD = (BIT_CYCLES * 3 + 1) / 2;

   // Synchronised pins
   logic [6:0] pin_sync;
   wire sel_s = pin_sync[0];
   wire lrx_s = pin_sync[1];
   wire lcd_s = pin_sync[2];
   wire rxd_s = pin_sync[3];
   wire rxc_s = pin_sync[4];
   wire crs_s = pin_sync[5];
   wire col_s = pin_sync[6];

   bit_sync #(
      .WIDTH (7)
   ) u_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .ce      (ce),
      .d       ({col_pin_in, crs_pin_in, rxc_pin_in, rxd_pin_in,
                 line_cd, line_rx, codec_select}),
      .q       (pin_sync)
   );

   logic int_carrier;
   logic int_nrz;
   logic int_rclk;
   logic int_strobe;

   manchester_rx #(
      .BIT_CYC  (BIT_CYCLES),
      .HOLD_CYC (HOLD),
      .TAIL_CYC (RXC_TAIL_CYC * BIT_CYCLES / BIT_CYC)
   ) u_rx (
      .pclk       (pclk),
      .presetn    (presetn),
      .ce         (ce),
      .line       (lrx_s),
      .carrier    (int_carrier),
      .nrz        (int_nrz),
      .rclk       (int_rclk),
      .bit_strobe (int_strobe)
   );

   // Codec select is a strap; mid-frame changes would tear the receive path
   logic [1:0] cfg_cnt;
   logic       cfg_done;
   logic       ext_mode;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_cnt  <= 2'b00;
         cfg_done <= 1'b0;
         ext_mode <= 1'b0;
      end else if (ce && !cfg_done) begin
         if (cfg_cnt == 2'(CFG_SETTLE - 1)) begin
            cfg_done <= 1'b1;
            ext_mode <= sel_s;
         end else begin
            cfg_cnt <= cfg_cnt + 2'b01;
         end
      end
   end

   // Internal collision: any edge of the collision signal recently
   logic       lcd_d;
   logic [3:0] col_hold;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lcd_d    <= 1'b0;
         col_hold <= 4'h0;
      end else if (ce) begin
         lcd_d <= lcd_s;
         if (lcd_s ^ lcd_d) begin
            col_hold <= 4'(COL_WIN_CYC);
         end else if (col_hold != 4'h0) begin
            col_hold <= col_hold - 4'h1;
         end
      end
   end

   wire int_col = (col_hold != 4'h0);

   // External receive clock edge
   logic rxc_d;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rxc_d <= 1'b0;
      end else if (ce) begin
         rxc_d <= rxc_s;
      end
   end

   wire ext_rise = rxc_s && !rxc_d;

   // MAC-facing receive path
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mac_carrier   <= 1'b0;
         mac_collision <= 1'b0;
         mac_rx_data   <= 1'b0;
         mac_rx_valid  <= 1'b0;
      end else if (ce) begin
         if (ext_mode) begin
            mac_carrier   <= crs_s;
            mac_collision <= col_s;
            mac_rx_valid  <= ext_rise && crs_s;
            if (ext_rise) begin
               mac_rx_data <= rxd_s;
            end
         end else begin
            mac_carrier   <= int_carrier;
            mac_collision <= int_col;
            mac_rx_valid  <= int_strobe;
            mac_rx_data   <= int_nrz;
         end
      end
   end

   // Registers
   logic [31:0]     data_config_reg;
   logic [31:0]     data_config_reg_second;
   logic [EV_W-1:0] status;
   logic [EV_W-1:0] mask;
   logic            dcr_written;
   logic            master_seen;
   logic [EV_W-1:0] events;

   wire setup  = psel && !penable;
   wire access = psel && penable && ce;
   wire mapped = (paddr == OFS_DCR) || (paddr == OFS_DATA_CONFIG_REG_SECOND) || (paddr == OFS_STATUS)
                 || (paddr == OFS_MASK) || (paddr == OFS_STATE);
   wire wr     = access && pwrite;
   wire rd_st  = access && !pwrite && (paddr == OFS_STATUS);

   assign pready  = ce;
   assign pslverr = psel && penable && !mapped;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         data_config_reg         <= DCR_RST;
         data_config_reg_second        <= DATA_CONFIG_REG_SECOND_RST;
         mask        <= MASK_RST[EV_W-1:0];
         dcr_written <= 1'b0;
      end else if (wr) begin
         case (paddr)
            OFS_DCR: begin
               data_config_reg         <= pwdata;
               dcr_written <= 1'b1;
            end
            OFS_DATA_CONFIG_REG_SECOND: data_config_reg_second <= pwdata;
            OFS_MASK: mask <= pwdata[EV_W-1:0];
            default:  ;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         master_seen <= 1'b0;
      end else if (ce && bus_master_grant) begin
         master_seen <= 1'b1;
      end
   end

   // A new event in the clearing read's cycle survives the clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status <= '0;
      end else if (ce) begin
         status <= (rd_st ? '0 : status) | events;
      end
   end

   assign irq = |(status & mask);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (ce && setup && !pwrite) begin
         case (paddr)
            OFS_DCR:    prdata <= data_config_reg;
            OFS_DATA_CONFIG_REG_SECOND:   prdata <= data_config_reg_second;
            OFS_STATUS: prdata <= {{(32-EV_W){1'b0}}, status};
            OFS_MASK:   prdata <= {{(32-EV_W){1'b0}}, mask};
            OFS_STATE: begin
               prdata               <= 32'h0000_0000;
               prdata[ST_CODEC_SEL] <= ext_mode;
               prdata[ST_CARRIER]   <= mac_carrier;
               prdata[ST_COLLISION] <= mac_collision;
               prdata[ST_DCR_WR]    <= dcr_written;
               prdata[ST_MASTER]    <= master_seen;
            end
            default:    prdata <= 32'h0000_0000;
         endcase
      end
   end

   // Collision during transmit and heartbeat after it
   hb_state_t  hb_state;
   logic [15:0] hb_cnt;
   logic       carrier_d;
   logic       col_d;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         carrier_d <= 1'b0;
         col_d     <= 1'b0;
      end else if (ce) begin
         carrier_d <= mac_carrier;
         col_d     <= mac_collision;
      end
   end

   wire col_rise = mac_collision && !col_d;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hb_state <= HB_IDLE;
         hb_cnt   <= 16'h0000;
      end else if (ce) begin
         case (hb_state)
            HB_IDLE: begin
               if (mac_tx_active) begin
                  hb_state <= HB_TX;
               end
            end
            HB_TX: begin
               if (!mac_tx_active) begin
                  hb_state <= HB_WAIT;
                  hb_cnt   <= 16'(HB_CYCLES - 1);
               end
            end
            HB_WAIT: begin
               if (mac_collision || mac_tx_active || hb_cnt == 16'h0000) begin
                  hb_state <= mac_tx_active ? HB_TX : HB_IDLE;
               end else begin
                  hb_cnt <= hb_cnt - 16'h0001;
               end
            end
            default: hb_state <= HB_IDLE;
         endcase
      end
   end

   always_comb begin
      events             = '0;
      events[EV_CARRIER] = mac_carrier && !carrier_d;
      events[EV_TX_COL]  = (hb_state == HB_TX) && mac_tx_active && col_rise;
      events[EV_HB_OK]   = (hb_state == HB_WAIT) && mac_collision;
      events[EV_HB_MISS] = (hb_state == HB_WAIT) && !mac_collision
                           && !mac_tx_active && (hb_cnt == 16'h0000);
   end

   // Shared pins
   wire ext_bus = data_config_reg[DCR_EXT_BUS];
   wire drive_int = cfg_done && !ext_mode;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rxd_pin_out  <= 1'b0;
         rxd_pin_oe_n <= 1'b1;
         rxc_pin_out  <= 1'b0;
         rxc_pin_oe_n <= 1'b1;
         crs_pin_out  <= 1'b0;
         crs_pin_oe_n <= 1'b1;
         col_pin_out  <= 1'b0;
         col_pin_oe_n <= 1'b1;
      end else if (ce) begin
         crs_pin_out  <= int_carrier;
         crs_pin_oe_n <= !drive_int;
         col_pin_out  <= int_col;
         col_pin_oe_n <= !drive_int;
         if (!dcr_written) begin
            rxd_pin_oe_n <= 1'b1;
            rxc_pin_oe_n <= 1'b1;
         end else if (ext_bus) begin
            rxd_pin_out  <= data_config_reg_second[DATA_CONFIG_REG_SECOND_USER0];
            rxd_pin_oe_n <= 1'b0;
            rxc_pin_out  <= data_config_reg_second[DATA_CONFIG_REG_SECOND_USER1];
            rxc_pin_oe_n <= !master_seen;
         end else begin
            rxd_pin_out  <= int_nrz;
            rxd_pin_oe_n <= !drive_int;
            rxc_pin_out  <= int_rclk;
            rxc_pin_oe_n <= !drive_int;
         end
      end
   end
endmodule

/* File: far_codec.sv */
/*
 Far-side model: the transceiver line and an outside codec.
 Assumes the bench merges its pin levels with the device's drivers.
*/
`timescale 1ns/100ps
module far_codec;
   logic line_rx = 1'b1;
   logic line_cd = 1'b0;
   logic rxd     = 1'b0;
   logic rxc     = 1'b0;
   logic crs     = 1'b0;
   logic col     = 1'b0;
   // Rising mid-cell edge carries a one; line idles high
   // Every task starts 5 ns off the clock edge so no pin change races pclk
   task automatic man_tx(input logic [15:0] bits);
      #5;
      for (int i = 0; i < 16; i++) begin
         line_rx = !bits[i];
         #160 line_rx = bits[i];
         #160;
      end
      line_rx = 1'b1;
   endtask
   // Transceiver collision signal at 10 MHz
   task automatic cd_burst(input int n);
      #5;
      repeat (n) #50 line_cd = !line_cd;
      line_cd = 1'b0;
   endtask
   // Receive clock runs only inside the frame
   task automatic ext_tx(input logic [15:0] bits);
      #5;
      crs = 1'b1;
      for (int i = 0; i < 16; i++) begin
         rxd = bits[i];
         #160 rxc = 1'b1;
         #160 rxc = 1'b0;
      end
      crs = 1'b0;
      // Released data line must not look like a valid level
      rxd = !rxd;
   endtask
   task automatic col_pulse();
      #5;
      col = 1'b1;
      #200 col = 1'b0;
   endtask
endmodule

/* File: codec_port_monitor.sv */
/*
 Checker for the codec serial port, bound to its top module.
 Assumes codec_select is steady around each reset.
*/
`timescale 1ns/100ps
module codec_port_monitor
   import codec_port_pkg::*;
#(
   parameter int BIT_CYCLES = 8
) (
   input wire logic       pclk,
   input wire logic       presetn,
   input wire logic       ce,
   input wire logic       psel,
   input wire logic       penable,
   input wire logic       pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic       pready,
   input wire logic       codec_select,
   input wire logic       line_rx,
   input wire logic       line_cd,
   input wire logic       bus_master_grant,
   input wire logic       rxd_pin_out,
   input wire logic       rxd_pin_oe_n,
   input wire logic       rxc_pin_out,
   input wire logic       rxc_pin_oe_n,
   input wire logic       crs_pin_oe_n,
   input wire logic       col_pin_oe_n,
   input wire logic       mac_carrier,
   input wire logic       mac_collision
);
   localparam int CRS_HOLD = (3 * BIT_CYCLES + 1) / 2;
   logic [3:0] rel_cnt;
   logic [7:0] rx_q;
   logic [7:0] cd_q;
   logic       sel_lat;
   logic       dcr_wr;
   logic       ext_bus;
   logic       u0;
   logic       u1;
   logic       seen_m;
   wire        wr_ok = psel && penable && pready && pwrite;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rel_cnt <= 4'h0;
         sel_lat <= 1'b0;
      end else if (ce && rel_cnt != 4'hf) begin
         rel_cnt <= rel_cnt + 4'h1;
         if (rel_cnt == 4'h0) sel_lat <= codec_select;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {dcr_wr, ext_bus, u1, u0, seen_m} <= 5'h0;
      end else begin
         if (wr_ok && paddr == OFS_DCR) begin
            dcr_wr  <= 1'b1;
            ext_bus <= pwdata[DCR_EXT_BUS];
         end
         if (wr_ok && paddr == OFS_DATA_CONFIG_REG_SECOND) {u1, u0} <= pwdata[1:0];
         if (ce && bus_master_grant) seen_m <= 1'b1;
      end
   end
   // Cycles since the raw line inputs last moved, saturating
   always_ff @(posedge pclk) begin
      rx_q <= $changed(line_rx) ? 8'h0 : rx_q + {7'h0, rx_q != 8'hff};
      cd_q <= $changed(line_cd) ? 8'h0 : cd_q + {7'h0, cd_q != 8'hff};
   end
   AST_RX_FLOAT: assert property (!dcr_wr |-> rxd_pin_oe_n && rxc_pin_oe_n)
      else $error("shared rx pins driven before config write");
   AST_INT_DRIVE: assert property (rel_cnt == 4'hf && !sel_lat |-> !crs_pin_oe_n && !col_pin_oe_n)
      else $error("internal codec status pins not driven");
   AST_EXT_FLOAT: assert property (rel_cnt == 4'hf && sel_lat |-> crs_pin_oe_n && col_pin_oe_n)
      else $error("status pins driven in external mode");
   AST_USER0: assert property (dcr_wr && ext_bus && $past(dcr_wr && ext_bus) && $stable(u0)
      |-> !rxd_pin_oe_n && rxd_pin_out == u0)
      else $error("user output 0 wrong");
   AST_USER1_FLOAT: assert property (dcr_wr && ext_bus && $past(dcr_wr && ext_bus) && !seen_m
      |-> rxc_pin_oe_n)
      else $error("user output 1 driven before bus master");
   AST_USER1_DRIVE: assert property ($past(seen_m, 2) && $past(dcr_wr && ext_bus) && dcr_wr
      && ext_bus && $stable(u1) |-> !rxc_pin_oe_n && rxc_pin_out == u1)
      else $error("user output 1 wrong after bus master");
   AST_CRS_HOLD: assert property ($fell(mac_carrier) && !sel_lat |-> rx_q >= CRS_HOLD)
      else $error("carrier dropped too soon after last line edge");
   AST_RXC_TAIL: assert property ($fell(mac_carrier) && !sel_lat && dcr_wr && !ext_bus
      |-> ##[17:24] $changed(rxc_pin_out))
      else $error("recovered clock stopped after carrier");
   AST_COL_CAUSE: assert property ($rose(mac_collision) && !sel_lat |-> cd_q < 8'd16)
      else $error("collision without collision signal");
endmodule
bind codec_serial_port codec_port_monitor #(.BIT_CYCLES(BIT_CYCLES)) mon (.pclk, .presetn, .ce,
   .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .codec_select, .line_rx, .line_cd,
   .bus_master_grant, .rxd_pin_out, .rxd_pin_oe_n, .rxc_pin_out, .rxc_pin_oe_n, .crs_pin_oe_n,
   .col_pin_oe_n, .mac_carrier, .mac_collision);

/* File: codec_serial_port_tb_top.sv */
/*
 Testbench for the codec serial port: APB tasks and directed scenarios.
 Assumes the far_codec model and the bound checker.
*/
`timescale 1ns/100ps
module codec_serial_port_tb_top;
   import codec_port_pkg::*;
   logic        pclk = 1'b0, presetn = 1'b0, ce = 1'b1;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0]  paddr = 8'h0;
   logic [31:0] pwdata = 32'h0, rd;
   logic        codec_select = 1'b0, bus_master_grant = 1'b0, mac_tx_active = 1'b0;
   logic        err;
   logic [7:0]  rx_shift = 8'h0;
   int          err_count = 0, n_tests = 0, cyc = 0;
   wire [31:0]  prdata;
   wire         pready, pslverr, irq, mac_carrier, mac_collision, mac_rx_data, mac_rx_valid;
   wire         rxd_pin_out, rxd_pin_oe_n, rxc_pin_out, rxc_pin_oe_n;
   wire         crs_pin_out, crs_pin_oe_n, col_pin_out, col_pin_oe_n;
   far_codec fc();
   // Wire level: device when it drives, else the far codec
   wire rxd_pin_in = rxd_pin_oe_n ? fc.rxd : rxd_pin_out;
   wire rxc_pin_in = rxc_pin_oe_n ? fc.rxc : rxc_pin_out;
   wire crs_pin_in = crs_pin_oe_n ? fc.crs : crs_pin_out;
   wire col_pin_in = col_pin_oe_n ? fc.col : col_pin_out;
   wire line_rx = fc.line_rx;
   wire line_cd = fc.line_cd;
   codec_serial_port #(.BIT_CYCLES(8), .HB_CYCLES(10)) dut (.pclk, .presetn, .ce, .psel,
      .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .irq, .codec_select,
      .line_rx, .line_cd, .rxd_pin_in, .rxd_pin_out, .rxd_pin_oe_n, .rxc_pin_in,
      .rxc_pin_out, .rxc_pin_oe_n, .crs_pin_in, .crs_pin_out, .crs_pin_oe_n, .col_pin_in,
      .col_pin_out, .col_pin_oe_n, .bus_master_grant, .mac_tx_active, .mac_carrier,
      .mac_collision, .mac_rx_data, .mac_rx_valid);
   always #20 pclk = ~pclk;
   always @(posedge pclk) begin
      if (mac_rx_valid) rx_shift <= {mac_rx_data, rx_shift[7:1]};
      cyc++;
      if (cyc == 20000) begin
         err_count++;
         end_sim();
      end
   end
   task automatic end_sim();
      $display("tests %0d errors %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_count++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Setup cycle, then access held until pready is seen high
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      {psel, penable} <= 2'b00;
   endtask
   // Select has to be steady until CFG_SETTLE cycles after the release of reset
   task automatic rst(input logic sel);
      codec_select <= sel;
      presetn <= 1'b0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      repeat (12) @(posedge pclk);
   endtask
   initial begin
      rst(1'b0);
      apb(0, OFS_STATE, 0); check(rd, 32'h0);
      check({rxd_pin_oe_n, rxc_pin_oe_n, crs_pin_oe_n}, 3'b110);
      apb(0, OFS_DATA_CONFIG_REG_SECOND, 0); check(rd, DATA_CONFIG_REG_SECOND_RST);
      apb(0, 8'h14, 0); check({err, rd[7:0]}, 9'h100);
      apb(1, OFS_DCR, 0);
      apb(1, OFS_MASK, 32'h1);
      repeat (2) @(posedge pclk);
      check({rxd_pin_oe_n, rxc_pin_oe_n}, 2'b00);
      fc.man_tx(16'ha5aa);
      check(irq, 1'b1);
      check({crs_pin_out, mac_carrier}, 2'b11);
      repeat (80) @(posedge pclk);
      check({crs_pin_out, mac_carrier}, 2'b00);
      // Bit strobe, gated by carrier, fires once more inside the 1.5-bit carrier tail,
      // so the last bit is clocked twice: bits 9..15 of 16'ha5aa, then bit 15
      check(rx_shift, 8'hd2);
      apb(0, OFS_STATUS, 0); check(rd, 32'h1);
      @(posedge pclk);
      check(irq, 1'b0);
      mac_tx_active <= 1'b1;
      fc.cd_burst(20);
      check({col_pin_out, mac_collision}, 2'b11);
      @(posedge pclk);
      mac_tx_active <= 1'b0;
      fc.cd_burst(10);
      repeat (20) @(posedge pclk);
      apb(0, OFS_STATUS, 0); check(rd, 32'h6);
      mac_tx_active <= 1'b1;
      repeat (5) @(posedge pclk);
      mac_tx_active <= 1'b0;
      repeat (20) @(posedge pclk);
      apb(0, OFS_STATUS, 0); check(rd, 32'h8);
      apb(1, OFS_DATA_CONFIG_REG_SECOND, 32'h3);
      apb(1, OFS_DCR, 32'h1);
      repeat (3) @(posedge pclk);
      check({rxd_pin_oe_n, rxd_pin_out, rxc_pin_oe_n}, 3'b011);
      // A grant while the clock enable is low must not be remembered
      ce <= 1'b0;
      bus_master_grant <= 1'b1;
      @(posedge pclk);
      check(pready, 1'b0);
      bus_master_grant <= 1'b0;
      @(posedge pclk);
      ce <= 1'b1;
      apb(0, OFS_STATE, 0); check(rd[4], 1'b0);
      bus_master_grant <= 1'b1;
      @(posedge pclk);
      bus_master_grant <= 1'b0;
      repeat (3) @(posedge pclk);
      check({rxc_pin_oe_n, rxc_pin_out}, 2'b01);
      apb(1, OFS_DATA_CONFIG_REG_SECOND, 0);
      repeat (3) @(posedge pclk);
      check({rxd_pin_out, rxc_pin_out}, 2'b00);
      codec_select <= 1'b1;
      repeat (10) @(posedge pclk);
      apb(0, OFS_STATE, 0); check(rd[4:0], 5'h18);
      rst(1'b1);
      check({crs_pin_oe_n, col_pin_oe_n}, 2'b11);
      apb(0, OFS_STATE, 0); check(rd[0], 1'b1);
      fc.ext_tx(16'ha5aa);
      repeat (10) @(posedge pclk);
      check(rx_shift, 8'ha5);
      apb(0, OFS_STATUS, 0);
      mac_tx_active <= 1'b1;
      fc.col_pulse();
      repeat (4) @(posedge pclk);
      apb(0, OFS_STATUS, 0); check(rd[1], 1'b1);
      mac_tx_active <= 1'b0;
      end_sim();
   end
endmodule
